// >>> common/ext_irq_map.svh
/*
  Register offsets, field positions, reset values and widths of the
  bus wake and flag clear block.
  Assumes inclusion by bare name from files that need these figures.
*/
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

// ==========================================================
// Offsets (byte addresses)
`define ADDR_WIDTH 12
`define OFS_BUS_WAKE_CONFIG 12'hA28
`define OFS_INTERRUPT_FLAG_CLEAR 12'hA30
`define OFS_FLAG_STATUS 12'hA34
`define OFS_FLAG_MASK 12'hA38

// ==========================================================
// Field positions
`define BIT_BUS_WAKE_ENABLE 3
`define BIT_BUS_AUTOCLEAR 15
`define BIT_EXT_AUTOCLEAR 14
`define BIT_BUS_FLAG_CLEAR 8
`define BIT_STATUS_BUS 8

// ==========================================================
// Reset values and masks
`define CFG_RESET 16'h0000
`define CLR_RESET 16'hC000
`define CFG_WRITE_MASK 16'h000F
`define FLAG_COUNT 9
`define FLAG_NONE 9'h000
`define EXT_COUNT 8

`endif

// >>> common/ext_irq_pkg.sv
/*
  Types shared by the bus wake and flag clear block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ext_irq_pkg;

  // ==========================================================
  // Detection modes, aliases folded by normMode
  typedef enum logic [2:0]
  {
    MODE_RISE = 3'b000,
    MODE_FALL = 3'b001,
    MODE_BOTH = 3'b010,
    MODE_HIGH = 3'b011,
    MODE_LOW = 3'b100
  } detect_mode_type;

  // Wake sequencing states
  typedef enum logic [1:0]
  {
    ST_AWAKE = 2'b00,
    ST_ASLEEP = 2'b01,
    ST_WAKING = 2'b10
  } wake_state_type;

  // Register port request
  typedef struct packed
  {
    logic [11:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // Flag set: bus flag above eight external flags
  typedef struct packed
  {
    logic bus;
    logic [7:0] ext;
  } flag_set_type;

  // Codes 101, 110, 111 alias falling, either edge, high level
  function automatic detect_mode_type normMode(input logic [2:0] code);
    case (code)
      3'b101: normMode = MODE_FALL;
      3'b110: normMode = MODE_BOTH;
      3'b111: normMode = MODE_HIGH;
      default: normMode = detect_mode_type'(code);
    endcase
  endfunction

endpackage

// >>> design/edge_level_detect.sv
/*
  Synchroniser and edge or level detector for one pin.
  Assumes an asynchronous pin and a mode from the register clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module edge_level_detect
  import ext_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pinIn,
  input wire logic [2:0] modeCode,
  output logic hit
);

  logic syncA_reg;
  logic syncB_reg;
  logic prev_reg;
  logic hit_next;

  // ==========================================================
  // Two flip-flops before any logic looks at the pin
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg;
      prev_reg <= syncB_reg;
    end
  end

  // Mode decode, aliases folded first
  always_comb
  begin
    case (normMode(modeCode)) // [R4] [R5]
      MODE_RISE: hit_next = syncB_reg & ~prev_reg;
      MODE_FALL: hit_next = ~syncB_reg & prev_reg;
      MODE_BOTH: hit_next = syncB_reg ^ prev_reg;
      MODE_HIGH: hit_next = syncB_reg;
      MODE_LOW: hit_next = ~syncB_reg;
      default: hit_next = 1'b0;
    endcase
  end

  // Registered so the output is a clean flop
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      hit <= 1'b0;
    else
      hit <= hit_next;
  end

endmodule

`default_nettype wire

// >>> design/ext_interrupt_wake_clear.sv
/*
  Bus wake-up detection and interrupt flag clear logic.
  Holds the bus wake configuration, the flag clear register, the
  flag status and mask registers and the wake sequencer.
  Assumes a single 200 MHz ref_clk, an asynchronous bus pin, external
  event pulses and a hibernate level from logic on ref_clk.
*/
// Decided for this implementation: the strobed register port.
// Contract
// [R1] Enabled bus activity wakes from hibernate
// [R2] Host enables bus wake before hibernating
// [R3] Bus wake disabled while enable is zero
// [R4] Mode codes: rise, fall, both, high, low
// [R5] Codes 101,110,111 alias fall, both, high
// [R6] Bit 15 autoclears bus flag, resets one
// [R7] Bit 14 autoclears external flags 0-7
// [R8] Writing bit 8 clears bus flag
// [R9] Writing bits 7..0 clears external flags
// [R10] Clear bits return to zero by hardware
// [R11] Clear register resets to C000
// [R12] Reserved bits zero; level condition re-sets flag
`include "ext_irq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ext_interrupt_wake_clear
  import ext_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire reg_req_type regReq,
  output logic [15:0] rdData,
  input wire logic busPin,
  input wire logic [7:0] extEvent,
  input wire logic hibernate,
  output logic wakeReq,
  output flag_set_type flags,
  output logic irqOut
);

  // ==========================================================
  // Declarations
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic busAutoClr_reg;
  logic extAutoClr_reg;
  logic [8:0] clrPulse_reg;
  logic [8:0] clrPulse_next;
  flag_set_type status_reg;
  flag_set_type status_next;
  flag_set_type mask_reg;
  flag_set_type setVec;
  flag_set_type clrVec;
  flag_set_type autoVec;
  logic [15:0] rdData_next;
  wake_state_type wakeState_reg;
  wake_state_type wakeState_next;
  logic wakeReq_next;
  logic busHit;
  logic busWakeEn;
  logic wrCfg;
  logic wrClr;
  logic wrStat;
  logic wrMask;
  logic rdStat;

  // ==========================================================
  // Address decode
  always_comb
  begin
    wrCfg = regReq.wr && (regReq.addr == `OFS_BUS_WAKE_CONFIG);
    wrClr = regReq.wr && (regReq.addr == `OFS_INTERRUPT_FLAG_CLEAR);
    wrStat = regReq.wr && (regReq.addr == `OFS_FLAG_STATUS);
    wrMask = regReq.wr && (regReq.addr == `OFS_FLAG_MASK);
    rdStat = regReq.rd && (regReq.addr == `OFS_FLAG_STATUS);
  end

  // ==========================================================
  // Bus pin detection
  // Synchroniser and mode decode live in the leaf module
  edge_level_detect busDetect
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pinIn(busPin),
    .modeCode(cfg_reg[2:0]),
    .hit(busHit)
  );

  // Enable gates both the flag and the wake path
  assign busWakeEn = cfg_reg[`BIT_BUS_WAKE_ENABLE];

  // ==========================================================
  // Bus wake configuration register
  // Only the enable and mode bits are stored
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wrCfg)
      cfg_next = regReq.wdata & `CFG_WRITE_MASK; // [R12]
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cfg_reg <= `CFG_RESET; // [R3]
    else
      cfg_reg <= cfg_next;
  end

  // ==========================================================
  // Flag clear register: autoclear enables
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busAutoClr_reg <= 1'b1; // [R6] [R11]
      extAutoClr_reg <= 1'b1; // [R11]
    end
    else if (wrClr)
    begin
      busAutoClr_reg <= regReq.wdata[`BIT_BUS_AUTOCLEAR];
      extAutoClr_reg <= regReq.wdata[`BIT_EXT_AUTOCLEAR];
    end
  end

  // ==========================================================
  // Flag clear register: self-resetting clear bits
  // A written one lives one cycle, acts, then drops by itself
  always_comb
  begin
    clrPulse_next = 9'h000; // [R10]
    if (wrClr)
      clrPulse_next = regReq.wdata[8:0]; // [R8] [R9]
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      clrPulse_reg <= 9'h000; // [R11]
    else
      clrPulse_reg <= clrPulse_next;
  end

  // ==========================================================
  // Flag set and clear terms
  // Autoclear acts on a read of the status register, so the read
  // still returns the flags that caused the interrupt
  always_comb
  begin
    setVec.bus = busHit && busWakeEn; // [R1] [R3]
    setVec.ext = extEvent;
    autoVec.bus = rdStat && busAutoClr_reg; // [R6]
    autoVec.ext = {`EXT_COUNT{rdStat && extAutoClr_reg}}; // [R7]
    clrVec = clrPulse_reg | autoVec; // [R8] [R9]
    if (wrStat)
      clrVec = clrVec | flag_set_type'(regReq.wdata[8:0]);
  end

  // ==========================================================
  // Status flags
  // Set wins over clear; a level mode whose condition stays present
  // sets the flag again in the very cycle of the clear
  always_comb
  begin
    status_next = (status_reg & ~clrVec) | setVec; // [R12]
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      status_reg <= `FLAG_NONE;
    else
      status_reg <= status_next;
  end

  // ==========================================================
  // Interrupt mask
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      mask_reg <= `FLAG_NONE;
    else if (wrMask)
      mask_reg <= regReq.wdata[8:0];
  end

  // Level output while any unmasked flag stands
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      irqOut <= 1'b0;
    else
      irqOut <= |(status_next & mask_reg);
  end

  assign flags = status_reg;

  // ==========================================================
  // Wake sequencer
  // A hit only wakes while enabled and hibernating; the host is
  // expected to enable before it requests hibernate
  always_comb
  begin
    wakeState_next = wakeState_reg;
    wakeReq_next = 1'b0;
    case (wakeState_reg)
      ST_AWAKE:
      begin
        if (hibernate)
          wakeState_next = ST_ASLEEP;
      end
      ST_ASLEEP:
      begin
        if (!hibernate)
          wakeState_next = ST_AWAKE;
        else if (busHit && busWakeEn) // [R1] [R2] [R3]
        begin
          wakeState_next = ST_WAKING;
          wakeReq_next = 1'b1;
        end
      end
      ST_WAKING:
      begin
        // Held until the power controller leaves hibernate
        wakeReq_next = hibernate;
        if (!hibernate)
          wakeState_next = ST_AWAKE;
      end
      default: wakeState_next = ST_AWAKE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      wakeState_reg <= ST_AWAKE;
    else
      wakeState_reg <= wakeState_next;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      wakeReq <= 1'b0;
    else
      wakeReq <= wakeReq_next;
  end

  // ==========================================================
  // Read data
  // Reserved and unmapped bits read as zero
  always_comb
  begin
    rdData_next = 16'h0000;
    if (regReq.rd)
    begin
      case (regReq.addr)
        `OFS_BUS_WAKE_CONFIG: rdData_next = cfg_reg; // [R12]
        `OFS_INTERRUPT_FLAG_CLEAR:
        begin
          rdData_next[`BIT_BUS_AUTOCLEAR] = busAutoClr_reg;
          rdData_next[`BIT_EXT_AUTOCLEAR] = extAutoClr_reg;
          rdData_next[8:0] = clrPulse_reg; // [R10]
        end
        `OFS_FLAG_STATUS: rdData_next[8:0] = status_reg;
        `OFS_FLAG_MASK: rdData_next[8:0] = mask_reg;
        default: rdData_next = 16'h0000;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rdData <= 16'h0000;
    else
      rdData <= rdData_next;
  end

endmodule

`default_nettype wire

// >>> tb/ext_irq_chk.sv
/* Port checker for the bus wake and flag clear block.
   Assumes binding to ext_interrupt_wake_clear on one clock. */
`timescale 1ns/1ps
`default_nettype none
module ext_irq_chk
  import ext_irq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire reg_req_type regReq,
  input wire logic [15:0] rdData,
  input wire logic busPin,
  input wire logic [7:0] extEvent,
  input wire logic hibernate,
  input wire logic wakeReq,
  input wire flag_set_type flags,
  input wire logic irqOut
);
  // ==========================================================
  // Timing relations at the ports
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  rd_quiet_a: assert property (!regReq.rd |=> rdData == 16'h0000)
    else $error("read data not zero outside a reply");
  cfg_res_a: assert property (regReq.rd && regReq.addr == 12'hA28
    |=> rdData[15:4] == 12'h000)
    else $error("config reserved bits not zero");
  clr_res_a: assert property (regReq.rd && regReq.addr == 12'hA30
    |=> rdData[13:9] == 5'h00)
    else $error("clear reserved bits not zero");
  ext_set_a: assert property (|extEvent
    |=> (flags.ext & $past(extEvent)) == $past(extEvent))
    else $error("external flag missed an event");
  ext_cause_a: assert property (
    (flags.ext & ~$past(flags.ext) & ~$past(extEvent)) == 8'h00)
    else $error("external flag set without event");
  // Two quiet cycles, since a fresh event would win over the clear
  ext_clear_a: assert property (regReq.wr && regReq.addr == 12'hA30 && extEvent == 8'h00
    ##1 extEvent == 8'h00 |=> (flags.ext & $past(regReq.wdata[7:0], 2)) == 8'h00)
    else $error("external flag not cleared");
  irq_cause_a: assert property (irqOut |-> flags != 9'h000)
    else $error("interrupt without a flag");
  wake_hold_a: assert property (wakeReq && hibernate |=> wakeReq)
    else $error("wake request dropped early");
  wake_drop_a: assert property (!hibernate [*3] |-> !wakeReq)
    else $error("wake request outlived hibernate");
  wake_cause_a: assert property ($rose(wakeReq) |-> flags.bus && $past(hibernate))
    else $error("wake without bus flag");
endmodule
bind ext_interrupt_wake_clear ext_irq_chk chk (.ref_clk(ref_clk), .nrst(nrst),
  .regReq(regReq), .rdData(rdData), .busPin(busPin), .extEvent(extEvent),
  .hibernate(hibernate), .wakeReq(wakeReq), .flags(flags), .irqOut(irqOut));
`default_nettype wire

// >>> tb/spi_host_model.sv
/* Host side of the serial bus: drives the bus activity pin.
   Assumes the bench asks for a pin level through actLevel. */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
  input wire logic actLevel,
  output logic busPin
);
  // ==========================================================
  // Pin follows the host off the clock grid, as a real pin would;
  // continuous so the pin follows actLevel 1.7 ns late, unknown only before 1.7 ns
  assign #1.7 busPin = actLevel;
endmodule
`default_nettype wire

// >>> tb/test_ext_interrupt_wake_clear.sv
/* Bench for the bus wake and flag clear block.
   Assumes the checker is bound and the host model drives busPin. */
`timescale 1ns/1ps
`default_nettype none
module test_ext_interrupt_wake_clear
  import ext_irq_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_type req = '0;
  logic [15:0] rdData;
  logic busPin;
  logic actLevel = 1'b0;
  logic [7:0] extEvent = 8'h00;
  logic hibernate = 1'b0;
  logic wakeReq;
  flag_set_type flags;
  logic irqOut;
  logic [2:0] code;
  int failures = 0;
  int n_tests = 0;

  ext_interrupt_wake_clear uut (.ref_clk(ref_clk), .nrst(nrst), .regReq(req),
    .rdData(rdData), .busPin(busPin), .extEvent(extEvent), .hibernate(hibernate),
    .wakeReq(wakeReq), .flags(flags), .irqOut(irqOut));
  spi_host_model host (.actLevel(actLevel), .busPin(busPin));

  // ==========================================================
  // Clock and bus tasks
  initial
    forever #2.5 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  // Reply stands one cycle only, so look right after the taking edge
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 chk("read data", exp, rdData);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge ref_clk);
    extEvent <= v;
    @(posedge ref_clk);
    extEvent <= 8'h00;
    @(posedge ref_clk);
    #1;
  endtask
  // Settle pin with detection off, clear, enable, then move the pin
  task automatic busPhase(input logic lvl, input logic exp);
    wr(12'hA28, {13'h0000, code});
    actLevel <= lvl;
    tick(6);
    wr(12'hA30, 16'h0100);
    tick(3);
    #1 chk("bus flag", 16'h0000, {15'h0000, flags.bus});
    wr(12'hA28, {12'h000, 1'b1, code});
    hibernate <= 1'b1;
    tick(2);
    actLevel <= ~lvl;
    tick(8);
    #1 chk("bus flag", {15'h0000, exp}, {15'h0000, flags.bus});
    chk("wake", {15'h0000, exp}, {15'h0000, wakeReq});
    @(posedge ref_clk);
    hibernate <= 1'b0;
    tick(3);
    #1 chk("wake", 16'h0000, {15'h0000, wakeReq});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    close_out();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(12'hA28, 16'h0000);
    rd(12'hA30, 16'hC000);
    wr(12'hA28, 16'hFFFB);
    rd(12'hA28, 16'h000B);
    wr(12'hA2C, 16'hFFFF);
    rd(12'hA2C, 16'h0000);
    wr(12'hA28, 16'h0000);
    $display("test registers done");
    wr(12'hA38, 16'h01FF);
    pulse(8'hA5);
    chk("irq", 16'h0001, {15'h0000, irqOut});
    rd(12'hA34, 16'h00A5);
    chk("flags", 16'h0000, {7'h00, flags});
    wr(12'hA30, 16'h0000);
    rd(12'hA30, 16'h0000);
    pulse(8'h3C);
    rd(12'hA34, 16'h003C);
    chk("flags", 16'h003C, {7'h00, flags});
    wr(12'hA30, 16'h0014);
    tick(2);
    #1 chk("flags", 16'h0028, {7'h00, flags});
    rd(12'hA30, 16'h0000);
    wr(12'hA34, 16'h0028);
    rd(12'hA34, 16'h0000);
    wr(12'hA38, 16'h0000);
    pulse(8'h01);
    chk("irq", 16'h0000, {15'h0000, irqOut});
    wr(12'hA34, 16'h0001);
    $display("test external flags done");
    // Every mode code, rising then falling pin
    for (int i = 0; i < 8; i++)
    begin
      code = 3'(i);
      busPhase(1'b0, !(code == 3'h1 || code == 3'h5));
      busPhase(1'b1, code != 3'h0);
    end
    $display("test bus wake done");
    close_out();
  end
endmodule
`default_nettype wire
